// ---- rco_refclk_top.sv ----
// Reference clock output block with its control register and power mode tracking.
`timescale 1ns/1ps
`default_nettype none
module rco_refclk_top
  import rco_pkg::*;
#(
  parameter int ADR_W = 8,
  parameter int DIV_W = RCO_DIV_W,
  parameter int CNT_W = RCO_CNT_W
) (
  input wire logic clk, // System clock, 10 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable, freezes all state when low.
  input wire logic [ADR_W-1:0] wb_adr_i, // Wishbone byte address.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic sys_clk_tick, // One pulse per system base clock edge.
  input wire logic pri_osc_tick, // One pulse per primary oscillator edge.
  input wire logic [1:0] osc_mode, // Oscillator configuration code.
  input wire logic primary_default, // Primary oscillator is the default clock.
  input wire logic clk_src_primary, // Device clock currently from primary.
  input wire logic sleep_cmd, // Sleep instruction executed, pulse.
  input wire logic idle_on_sleep_select, // Idle rather than Sleep on sleep_cmd.
  input wire logic wake, // Wake-up event, pulse.
  output logic ref_clock_pin_o, // Reference clock pin level.
  output logic ref_clock_pin_oe, // Reference clock pin drive enable.
  output logic osc_power_en, // Primary oscillator powered.
  output logic in_sleep, // Device in Sleep.
  output logic in_idle // Device in an Idle mode.
);

  // ----------------------------------------------------------------
  // Control register and decoded fields
  // ----------------------------------------------------------------
  logic [7:0] reference_output_control;
  logic ref_output_enable;
  logic ref_run_in_sleep;
  logic ref_source_select;
  logic [DIV_W-1:0] ref_divisor_select;

  assign ref_output_enable = reference_output_control[RCO_EN_BIT];
  assign ref_run_in_sleep = reference_output_control[RCO_SLP_BIT];
  assign ref_source_select = reference_output_control[RCO_SRC_BIT];
  assign ref_divisor_select = reference_output_control[RCO_DIV_LSB +: DIV_W];

  // ----------------------------------------------------------------
  // Power mode tracking
  // ----------------------------------------------------------------
  rco_pm_t pm;
  rco_pm_t next_pm;

  always_comb begin
    next_pm = pm;
    case (pm)
      RCO_PM_RUN: begin
        if (sleep_cmd) begin
          next_pm = idle_on_sleep_select ? RCO_PM_IDLE : RCO_PM_SLEEP;
        end
      end
      RCO_PM_IDLE, RCO_PM_SLEEP: begin
        if (wake) begin
          next_pm = RCO_PM_RUN;
        end
      end
      default: begin
        next_pm = RCO_PM_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pm <= RCO_PM_RUN;
    end else if (ce) begin
      pm <= next_pm;
    end
  end

  assign in_sleep = (pm == RCO_PM_SLEEP);
  assign in_idle = (pm == RCO_PM_IDLE);

  // ----------------------------------------------------------------
  // Base clock availability
  // ----------------------------------------------------------------
  logic ec_or_hs;
  logic primary_idle_mode;
  logic sleep_keep;
  logic run_ok;
  logic tick_sys_g;
  logic tick_pri_g;

  assign ec_or_hs = (osc_mode == RCO_OSC_EXTERNAL_CLOCK) ||
                    (osc_mode == RCO_OSC_HIGH_SPEED_CRYSTAL);
  assign primary_idle_mode = in_idle && clk_src_primary;
  // Only this combination may keep the oscillator alive through Sleep.
  assign sleep_keep = ref_output_enable && ref_run_in_sleep &&
                      ref_source_select && ec_or_hs;
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_power_en <= 1'b1;
    end else if (ce) begin
      osc_power_en <= (next_pm == RCO_PM_RUN) ||
                      ((next_pm == RCO_PM_IDLE) && clk_src_primary) ||
                      ((next_pm == RCO_PM_SLEEP) && sleep_keep);
    end
  end

  // The system clock stops in Sleep, so its edges are ignored there.
  assign tick_sys_g = sys_clk_tick && !in_sleep;
  assign tick_pri_g = pri_osc_tick && primary_default && osc_power_en;

  // Outside Sleep every mode may feed the output, whatever the oscillator.
  assign run_ok = ref_output_enable && (!in_sleep || sleep_keep);

  // ----------------------------------------------------------------
  // Divider and pin
  // ----------------------------------------------------------------
  logic div_out;
  logic act_src;
  logic halt;

  // A halt drops the pin at once; its base clock is gone, so no edge is lost.
  // A stopped or unconfigured primary halts too, else the pin could freeze high.
  assign halt = (in_sleep && (!sleep_keep || !act_src)) ||
                (act_src && !(primary_default && osc_power_en));

  rco_divider #(
    .DIV_W(DIV_W),
    .CNT_W(CNT_W)
  ) u_div (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .en(run_ok),
    .halt(halt),
    .src_sel(ref_source_select),
    .div_sel(ref_divisor_select),
    .tick_sys(tick_sys_g),
    .tick_pri(tick_pri_g),
    .out(div_out),
    .act_src(act_src)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_clock_pin_o <= 1'b0;
      ref_clock_pin_oe <= 1'b0;
    end else if (ce) begin
      ref_clock_pin_o <= div_out;
      ref_clock_pin_oe <= run_ok;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave, one wait state, ack for one cycle
  // ----------------------------------------------------------------
  logic req;
  logic hit_ctrl;
  logic hit_stat;
  logic [31:0] stat_word;

  assign req = wb_cyc_i && wb_stb_i;
  assign hit_ctrl = (wb_adr_i[7:0] == RCO_CTRL_OFS);
  assign hit_stat = (wb_adr_i[7:0] == RCO_STAT_OFS);
  assign stat_word = {24'h000000, ref_clock_pin_o, ref_clock_pin_oe, osc_power_en,
                      act_src, 2'h0, pm};

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= req && !wb_ack_o;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (ce) begin
      if (req && !wb_ack_o && !wb_we_i) begin
        if (hit_ctrl) begin
          wb_dat_o <= {24'h000000, reference_output_control};
        end else if (hit_stat) begin
          wb_dat_o <= stat_word;
        end else begin
          wb_dat_o <= 32'h00000000;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reference_output_control <= RCO_CTRL_RST;
    end else if (ce) begin
      if (req && wb_ack_o && wb_we_i && hit_ctrl && wb_sel_i[0]) begin
        reference_output_control <= wb_dat_i[7:0] & RCO_CTRL_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_reset_clear: assert property (@(posedge clk)
    $past(rst) |-> (reference_output_control == 8'h00 && !ref_clock_pin_oe))
    else $error("control not cleared by reset");

  a_bit6_zero: assert property (@(posedge clk) disable iff (rst)
    !reference_output_control[RCO_UNUSED_BIT])
    else $error("unimplemented control bit became set");

  a_oe_off: assert property (@(posedge clk) disable iff (rst)
    (ce && !ref_output_enable) |=> !ref_clock_pin_oe)
    else $error("pin driven while output disabled");

  a_sleep_stop: assert property (@(posedge clk) disable iff (rst)
    (ce && in_sleep && !ref_run_in_sleep) |=> (!ref_clock_pin_oe && !div_out))
    else $error("output active in Sleep without run-in-sleep");

  a_sleep_source: assert property (@(posedge clk) disable iff (rst)
    (ce && next_pm == RCO_PM_SLEEP && (!ref_source_select || !ec_or_hs)) |=> !osc_power_en)
    else $error("oscillator left powered in Sleep");

  a_primary_idle_mode: assert property (@(posedge clk) disable iff (rst)
    (ce && next_pm == RCO_PM_IDLE && clk_src_primary) |=> osc_power_en)
    else $error("primary oscillator stopped in primary idle");

  a_primary_idle_mode_keep: assert property (@(posedge clk) disable iff (rst)
    (primary_idle_mode && $past(primary_idle_mode)) |-> osc_power_en)
    else $error("oscillator stopped during primary idle");

  a_lost_base: assert property (@(posedge clk) disable iff (rst)
    (ce && act_src && !(primary_default && osc_power_en)) |=> !div_out)
    else $error("divider ran without its primary base clock");

  a_pri_default: assert property (@(posedge clk) disable iff (rst)
    !primary_default |-> !tick_pri_g)
    else $error("primary edge used while not the default clock");

  a_sleep_entry: assert property (@(posedge clk) disable iff (rst)
    (ce && pm == RCO_PM_RUN && sleep_cmd) |=> (in_idle == $past(idle_on_sleep_select)))
    else $error("sleep command entered the wrong mode");

  a_ack_once: assert property (@(posedge clk) disable iff (rst)
    (ce && wb_ack_o) |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

endmodule // rco_refclk_top
`default_nettype wire

// ---- rco_pkg.sv ----
// Constants and types shared by the reference clock output divider.
`default_nettype none
package rco_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RCO_CTRL_OFS = 8'h00;
  localparam logic [7:0] RCO_STAT_OFS = 8'h04;
  localparam logic [7:0] RCO_CTRL_RST = 8'h00;
  localparam logic [7:0] RCO_CTRL_MASK = 8'hbf;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int RCO_EN_BIT = 7;
  localparam int RCO_UNUSED_BIT = 6;
  localparam int RCO_SLP_BIT = 5;
  localparam int RCO_SRC_BIT = 4;
  localparam int RCO_DIV_LSB = 0;
  localparam int RCO_DIV_W = 4;
  localparam int RCO_CNT_W = 15;

  // ----------------------------------------------------------------
  // Oscillator configuration codes and power modes
  // ----------------------------------------------------------------
  localparam logic [1:0] RCO_OSC_EXTERNAL_CLOCK = 2'h0;
  localparam logic [1:0] RCO_OSC_HIGH_SPEED_CRYSTAL = 2'h1;
  localparam logic [1:0] RCO_OSC_INTERNAL = 2'h2;
  localparam logic [1:0] RCO_OSC_OTHER = 2'h3;

  typedef enum logic [1:0] {
    RCO_PM_RUN,
    RCO_PM_IDLE,
    RCO_PM_SLEEP
  } rco_pm_t;

endpackage : rco_pkg
`default_nettype wire

// ---- rco_divider.sv ----
// Glitch-free power-of-two divider for the reference clock output.
`timescale 1ns/1ps
`default_nettype none
module rco_divider
  import rco_pkg::*;
#(
  parameter int DIV_W = RCO_DIV_W,
  parameter int CNT_W = RCO_CNT_W
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable.
  input wire logic en, // Requested output enable.
  input wire logic halt, // Base clock removed, stop at once.
  input wire logic src_sel, // Requested source, 1 selects primary.
  input wire logic [DIV_W-1:0] div_sel, // Requested divisor code.
  input wire logic tick_sys, // System base clock edge.
  input wire logic tick_pri, // Primary base clock edge.
  output logic out, // Divided clock.
  output logic act_src // Source in use.
);

  logic act_en;
  logic [DIV_W-1:0] act_div;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] lim;
  logic tick;
  logic boundary;

  assign tick = act_src ? tick_pri : tick_sys;
  assign lim = CNT_W'((32'd1 << act_div) - 32'd1);
  assign boundary = tick && (cnt == lim);

  // ----------------------------------------------------------------
  // Settings are taken while the output is low, or on a halt that drives it low,
  // so a change alone can never shorten a phase already on the pin.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      act_en <= 1'b0;
      act_src <= 1'b0;
      act_div <= '0;
      cnt <= '0;
      out <= 1'b0;
    end else if (ce) begin
      if (halt) begin
        // The pin is held low here, so new settings cannot cut a phase short.
        act_en <= 1'b0;
        act_src <= src_sel;
        act_div <= div_sel;
        cnt <= '0;
        out <= 1'b0;
      end else if (!out && (!act_en || boundary)) begin
        act_en <= en;
        act_src <= src_sel;
        act_div <= div_sel;
        cnt <= '0;
        out <= act_en && en;
      end else if (boundary) begin
        cnt <= '0;
        out <= 1'b0;
      end else if (tick) begin
        cnt <= cnt + CNT_W'(1);
      end
    end
  end

  a_hold_low: assert property (@(posedge clk) disable iff (rst)
    (ce && !act_en && !out) |=> !out)
    else $error("divider output rose while disabled");

  a_div_one: assert property (@(posedge clk) disable iff (rst)
    (ce && !halt && act_en && act_div == '0 && out && tick) |=> !out)
    else $error("undivided output missed a base edge");

endmodule // rco_divider
`default_nettype wire

// ---- rco_clk_sink.sv ----
// Model of an external device that counts and times the reference clock it receives.
`timescale 1ns/1ps
`default_nettype none
module rco_clk_sink (
  input wire logic clk, // Sampling clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic pin, // Reference clock pin level.
  input wire logic oe, // Pin drive enable.
  output logic [15:0] edges, // Rising edges seen while driven.
  output logic [15:0] high_len // Length of the last high phase in cycles.
);
  logic prev;
  logic [15:0] run;
  wire logic lvl = pin & oe;
  // A pin that is not driven reads low, as the pull-down on the board makes it.
  always_ff @(posedge clk) begin
    if (rst) begin
      prev <= 1'b0;
      run <= 16'h0000;
      edges <= 16'h0000;
      high_len <= 16'h0000;
    end else begin
      prev <= lvl;
      run <= lvl ? run + 16'h0001 : 16'h0000;
      if (lvl && !prev) edges <= edges + 16'h0001;
      if (!lvl && prev) high_len <= run;
    end
  end
endmodule // rco_clk_sink
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking testbench for the reference clock output block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rco_pkg::*;
  logic clk, rst, cyc, stb, we, st, pt, pd, slp, idl, wk, csp;
  logic [7:0] adr;
  logic [31:0] dat, dat_o, rd;
  logic [3:0] sel;
  logic [1:0] om;
  logic ack, pin, oe, pwr, in_sleep, in_idle;
  logic [15:0] edges, high_len, e0;
  int error_cnt, checked, cyc_cnt;
  typedef struct {logic [7:0] c; logic s, p, d; int h;} rco_row_t;
  rco_row_t rows[7] = '{'{8'h80, 1, 0, 1, 1}, '{8'h81, 1, 0, 1, 2}, '{8'h83, 1, 0, 1, 8},
    '{8'h84, 1, 0, 1, 16}, '{8'h90, 0, 1, 1, 1}, '{8'h90, 0, 1, 0, 0}, '{8'h00, 1, 1, 1, 0}};

  rco_refclk_top dut (.clk(clk), .rst(rst), .ce(1'b1), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .sys_clk_tick(st), .pri_osc_tick(pt), .osc_mode(om),
    .primary_default(pd), .clk_src_primary(csp), .sleep_cmd(slp),
    .idle_on_sleep_select(idl), .wake(wk), .ref_clock_pin_o(pin), .ref_clock_pin_oe(oe),
    .osc_power_en(pwr), .in_sleep(in_sleep), .in_idle(in_idle));
  rco_clk_sink sink (.clk(clk), .rst(rst), .pin(pin), .oe(oe), .edges(edges),
    .high_len(high_len));

  // ----------------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus and pulse helpers
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input logic idle_sel);
    @(posedge clk);
    slp <= 1'b1;
    idl <= idle_sel;
    @(posedge clk);
    slp <= 1'b0;
    repeat (40) @(posedge clk);
    e0 = edges;
    repeat (80) @(posedge clk);
  endtask
  task automatic wakeup();
    @(posedge clk);
    wk <= 1'b1;
    @(posedge clk);
    wk <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, cyc, stb, we, st, pt, slp, idl, wk, csp} = '0;
    {adr, dat, om, error_cnt, checked, cyc_cnt} = '0;
    pd = 1'b1;
    sel = 4'hf;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, RCO_CTRL_OFS, '0);
    chk("ctrl reset", rd, {24'h0, RCO_CTRL_RST});
    chk("oe reset", oe, 1'b0);
    foreach (rows[i]) begin
      wb(1'b1, RCO_CTRL_OFS, {24'h0, rows[i].c});
      wb(1'b0, RCO_CTRL_OFS, '0);
      chk("ctrl", rd, {24'h0, rows[i].c});
      // The old base clock keeps ticking until new settings are taken at a low-phase end.
      repeat (40) @(posedge clk);
      st <= rows[i].s;
      pt <= rows[i].p;
      pd <= rows[i].d;
      repeat (40) @(posedge clk);
      e0 = edges;
      repeat (80) @(posedge clk);
      chk("oe", oe, rows[i].c[7]);
      if (rows[i].h == 0) begin
        chk("idle edges", edges - e0, 0);
        chk("pin idle", pin, 1'b0);
      end else begin
        chk("high phase", high_len, rows[i].h);
      end
    end
    // Enable stays off here: divide-by-65536 has a 32768-cycle low phase that would outlast the run.
    wb(1'b1, RCO_CTRL_OFS, 32'hffffff7f);
    wb(1'b0, RCO_CTRL_OFS, '0);
    chk("bit6", rd, 32'h3f);
    sel <= 4'he;
    wb(1'b1, RCO_CTRL_OFS, 32'h80);
    sel <= 4'hf;
    wb(1'b0, RCO_CTRL_OFS, '0);
    chk("sel ignored", rd, 32'h3f);
    wb(1'b0, 8'h08, '0);
    chk("unmapped", rd, 32'h0);
    // Sleep with every condition met keeps the pin toggling.
    st <= 1'b1;
    pt <= 1'b1;
    pd <= 1'b1;
    wb(1'b1, RCO_CTRL_OFS, 32'hb0);
    pulse(1'b0);
    chk("in sleep", in_sleep, 1'b1);
    chk("sleep edges", edges - e0 > 16'h0, 1'b1);
    chk("osc kept", pwr, 1'b1);
    wakeup();
    wb(1'b1, RCO_CTRL_OFS, 32'h90);
    pulse(1'b0);
    chk("no run in sleep", edges - e0, 0);
    chk("pin sleep", pin, 1'b0);
    chk("osc off", pwr, 1'b0);
    wb(1'b0, RCO_STAT_OFS, '0);
    chk("status sleep", rd, 32'h12);
    wakeup();
    om <= RCO_OSC_INTERNAL;
    wb(1'b1, RCO_CTRL_OFS, 32'hb0);
    pulse(1'b0);
    chk("internal sleep", edges - e0, 0);
    chk("internal osc off", pwr, 1'b0);
    wakeup();
    pulse(1'b1);
    chk("in idle", in_idle, 1'b1);
    chk("not sleep", in_sleep, 1'b0);
    chk("idle osc off", pwr, 1'b0);
    chk("idle pin", pin, 1'b0);
    wakeup();
    // Primary idle keeps the oscillator, so the pin runs on even in internal mode.
    csp <= 1'b1;
    pulse(1'b1);
    chk("primary_idle_mode osc", pwr, 1'b1);
    chk("primary_idle_mode edges", edges - e0 > 16'h0, 1'b1);
    // Reset in mid-run, from primary idle with the output toggling.
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk("mode reset", in_idle, 1'b0);
    wb(1'b0, RCO_CTRL_OFS, '0);
    chk("ctrl mid reset", rd, {24'h0, RCO_CTRL_RST});
    chk("oe mid reset", oe, 1'b0);
    chk("pin mid reset", pin, 1'b0);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
